// ### hw/mcsbd_main_clock_select.sv
// Main clock select and bus dividers with Avalon-MM register slave
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/100ps
// Functional notes
// - Main clock follows 3-bit source select
// - Divide enable zero passes main clock
// - Enabled divider gives main over 2^(ratio+1)
// - CPU select write clears ready flag
// - Fast bus select mirrors CPU select, read-only
// - Peripheral bus dividers work like CPU divider
// - Peripheral select write clears ready flag
// - Ready flag rises once settings take effect
module mcsbd_main_clock_select
  import mcsbd_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic system_rc_oscillator,
  input wire logic crystal_oscillator,
  input wire logic frequency_locked_loop,
  input wire logic fast_rc_oscillator,
  output logic main_clock,
  output logic cpu_clock,
  output logic fast_bus_clock,
  output logic periph_bus_a_clock,
  output logic periph_bus_b_clock,
  output logic clock_settings_ready,
  output logic [31:0] cpu_clock_gates,
  output logic [31:0] fast_bus_clock_gates,
  output logic [31:0] periph_bus_a_clock_gates,
  output logic [31:0] periph_bus_b_clock_gates,
  output logic [6:0] divided_clock_gates
);
  initial begin
    if (ADDR_W != 10) begin
      $error("ADDR_W must be 10");
    end
  end

  mcsbd_state_t s_ff;
  mcsbd_state_t nxt_s;
  logic wr;
  logic [31:0] wmask;

  function automatic logic [31:0] sel_word(input mcsbd_div_t d);
    logic [31:0] w;
    w = 32'h00000000;
    w[DIV_EN_BIT] = d.en;
    w[2:0] = d.ratio;
    return w;
  endfunction

  function automatic mcsbd_div_t sel_field(input logic [31:0] w);
    mcsbd_div_t d;
    d.en = w[DIV_EN_BIT];
    d.ratio = w[2:0];
    return d;
  endfunction

  // Half period of 2^(ratio+1) is 2^ratio mclk samples with main clock high
  function automatic logic [7:0] half_period(input mcsbd_div_t d);
    return 8'h01 << d.ratio;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] m,
                                        input logic [31:0] w);
    return (old & ~m) | (w & m);
  endfunction

  always_comb begin
    wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
             {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  end

  // One wait cycle per access; the request completes when rvalid is set
  assign avs_waitrequest = (avs_read | avs_write) & ~s_ff.rvalid;
  assign wr = avs_write & ~s_ff.rvalid;
  assign avs_readdata = s_ff.rdata;

  always_comb begin
    nxt_s = s_ff;
    nxt_s.rvalid = (avs_read | avs_write) & ~s_ff.rvalid;
    if (wr) begin
      unique case (avs_address)
        OFS_MAIN_SRC: begin
          if (avs_byteenable[0]) begin
            nxt_s.main_sel = avs_writedata[2:0];
          end
        end
        OFS_CPU_DIV: begin
          nxt_s.cpu = sel_field(merge(sel_word(s_ff.cpu), wmask, avs_writedata));
        end
        OFS_PBA_DIV: begin
          nxt_s.pba = sel_field(merge(sel_word(s_ff.pba), wmask, avs_writedata));
        end
        OFS_PBB_DIV: begin
          nxt_s.pbb = sel_field(merge(sel_word(s_ff.pbb), wmask, avs_writedata));
        end
        OFS_CPU_GATES: nxt_s.cpu_gates = merge(s_ff.cpu_gates, wmask, avs_writedata);
        OFS_FAST_GATES: nxt_s.fast_gates = merge(s_ff.fast_gates, wmask, avs_writedata);
        OFS_PBA_GATES: nxt_s.pba_gates = merge(s_ff.pba_gates, wmask, avs_writedata);
        OFS_PBB_GATES: nxt_s.pbb_gates = merge(s_ff.pbb_gates, wmask, avs_writedata);
        OFS_DIV_GATES: begin
          if (avs_byteenable[0]) begin
            nxt_s.div_gates = avs_writedata[6:0];
          end
        end
        OFS_FAIL_CTRL: nxt_s.fail_ctrl = merge(s_ff.fail_ctrl, wmask, avs_writedata);
        OFS_PERIPH_POWER_CONTROL: nxt_s.periph_power_control = merge(s_ff.periph_power_control, wmask, avs_writedata);
        OFS_WAKE_EN: nxt_s.wake_en = merge(s_ff.wake_en, wmask, avs_writedata);
        default: begin
        end
      endcase
    end

    // Ready handshake on divider select writes
    unique case (s_ff.st)
      ST_READY: begin
      end
      ST_SETTLE: begin
        if (s_ff.settle == 4'h0) begin
          nxt_s.st = ST_READY;
        end else begin
          nxt_s.settle = s_ff.settle - 4'h1;
        end
      end
      default: nxt_s.st = ST_READY;
    endcase
    if (wr && (avs_address == OFS_CPU_DIV || avs_address == OFS_PBA_DIV
               || avs_address == OFS_PBB_DIV)) begin
      nxt_s.st = ST_SETTLE;
      nxt_s.settle = SETTLE_CYCLES;
    end

    // Dividers count mclk cycles in which main clock is sampled high
    if (main_clock) begin
      nxt_s.cnt_cpu = s_ff.cnt_cpu + 8'h01;
      if (s_ff.cnt_cpu + 8'h01 >= half_period(s_ff.cpu)) begin
        nxt_s.cnt_cpu = 8'h00;
        nxt_s.clk_cpu = ~s_ff.clk_cpu;
      end
      nxt_s.cnt_pba = s_ff.cnt_pba + 8'h01;
      if (s_ff.cnt_pba + 8'h01 >= half_period(s_ff.pba)) begin
        nxt_s.cnt_pba = 8'h00;
        nxt_s.clk_pba = ~s_ff.clk_pba;
      end
      nxt_s.cnt_pbb = s_ff.cnt_pbb + 8'h01;
      if (s_ff.cnt_pbb + 8'h01 >= half_period(s_ff.pbb)) begin
        nxt_s.cnt_pbb = 8'h00;
        nxt_s.clk_pbb = ~s_ff.clk_pbb;
      end
    end

    if ((avs_read | avs_write) && !s_ff.rvalid) begin
      unique case (avs_address)
        OFS_MAIN_SRC: nxt_s.rdata = {29'h0, s_ff.main_sel};
        OFS_CPU_DIV: nxt_s.rdata = sel_word(s_ff.cpu);
        OFS_FAST_DIV: nxt_s.rdata = sel_word(s_ff.cpu);
        OFS_PBA_DIV: nxt_s.rdata = sel_word(s_ff.pba);
        OFS_PBB_DIV: nxt_s.rdata = sel_word(s_ff.pbb);
        OFS_CPU_GATES: nxt_s.rdata = s_ff.cpu_gates;
        OFS_FAST_GATES: nxt_s.rdata = s_ff.fast_gates;
        OFS_PBA_GATES: nxt_s.rdata = s_ff.pba_gates;
        OFS_PBB_GATES: nxt_s.rdata = s_ff.pbb_gates;
        OFS_DIV_GATES: nxt_s.rdata = {25'h0, s_ff.div_gates};
        OFS_FAIL_CTRL: nxt_s.rdata = s_ff.fail_ctrl;
        OFS_STATUS: nxt_s.rdata = 32'(s_ff.st == ST_READY) << READY_BIT;
        OFS_PERIPH_POWER_CONTROL: nxt_s.rdata = s_ff.periph_power_control;
        OFS_WAKE_EN: nxt_s.rdata = s_ff.wake_en;
        OFS_CONFIG: nxt_s.rdata = RST_CONFIG;
        OFS_REVISION: nxt_s.rdata = REVISION_CODE;
        default: nxt_s.rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (rst) begin
      s_ff.main_sel <= SRC_SYS_RC;
      s_ff.cpu <= sel_field(RST_SEL);
      s_ff.pba <= sel_field(RST_SEL);
      s_ff.pbb <= sel_field(RST_SEL);
      s_ff.cpu_gates <= RST_CPU_GATES;
      s_ff.fast_gates <= RST_FAST_GATES;
      s_ff.pba_gates <= RST_PBA_GATES;
      s_ff.pbb_gates <= RST_PBB_GATES;
      s_ff.div_gates <= RST_DIV_GATES[6:0];
      s_ff.fail_ctrl <= RST_SEL;
      s_ff.periph_power_control <= RST_PERIPH_POWER_CONTROL;
      s_ff.wake_en <= RST_SEL;
      s_ff.st <= ST_READY;
      s_ff.settle <= 4'h0;
      s_ff.cnt_cpu <= 8'h00;
      s_ff.cnt_pba <= 8'h00;
      s_ff.cnt_pbb <= 8'h00;
      s_ff.clk_cpu <= 1'b0;
      s_ff.clk_pba <= 1'b0;
      s_ff.clk_pbb <= 1'b0;
      s_ff.rvalid <= 1'b0;
      s_ff.rdata <= 32'h00000000;
    end else begin
      s_ff <= nxt_s;
    end
  end

  always_comb begin
    unique case (s_ff.main_sel)
      SRC_CRYSTAL: main_clock = crystal_oscillator;
      SRC_FLL: main_clock = frequency_locked_loop;
      SRC_FAST_RC: main_clock = fast_rc_oscillator;
      default: main_clock = system_rc_oscillator;
    endcase
  end

  assign cpu_clock = s_ff.cpu.en ? s_ff.clk_cpu : main_clock;
  assign fast_bus_clock = cpu_clock;
  assign periph_bus_a_clock = s_ff.pba.en ? s_ff.clk_pba : main_clock;
  assign periph_bus_b_clock = s_ff.pbb.en ? s_ff.clk_pbb : main_clock;
  assign clock_settings_ready = (s_ff.st == ST_READY);
  assign cpu_clock_gates = s_ff.cpu_gates;
  assign fast_bus_clock_gates = s_ff.fast_gates;
  assign periph_bus_a_clock_gates = s_ff.pba_gates;
  assign periph_bus_b_clock_gates = s_ff.pbb_gates;
  assign divided_clock_gates = s_ff.div_gates;
endmodule

// ### hw/mcsbd_pkg.sv
// Package: register map, fields, reset values and types of the clock select block
package mcsbd_pkg;
  localparam logic [9:0] OFS_MAIN_SRC = 10'h000;
  localparam logic [9:0] OFS_CPU_DIV = 10'h004;
  localparam logic [9:0] OFS_FAST_DIV = 10'h008;
  localparam logic [9:0] OFS_PBA_DIV = 10'h00c;
  localparam logic [9:0] OFS_PBB_DIV = 10'h010;
  localparam logic [9:0] OFS_CPU_GATES = 10'h020;
  localparam logic [9:0] OFS_FAST_GATES = 10'h024;
  localparam logic [9:0] OFS_PBA_GATES = 10'h028;
  localparam logic [9:0] OFS_PBB_GATES = 10'h02c;
  localparam logic [9:0] OFS_DIV_GATES = 10'h040;
  localparam logic [9:0] OFS_FAIL_CTRL = 10'h054;
  localparam logic [9:0] OFS_UNLOCK = 10'h058;
  localparam logic [9:0] OFS_IRQ_SET = 10'h0c0;
  localparam logic [9:0] OFS_IRQ_CLR = 10'h0c4;
  localparam logic [9:0] OFS_IRQ_STATE = 10'h0c8;
  localparam logic [9:0] OFS_IRQ_PEND = 10'h0cc;
  localparam logic [9:0] OFS_IRQ_PCLR = 10'h0d0;
  localparam logic [9:0] OFS_STATUS = 10'h0d4;
  localparam logic [9:0] OFS_PERIPH_POWER_CONTROL = 10'h160;
  localparam logic [9:0] OFS_RST_SRC = 10'h180;
  localparam logic [9:0] OFS_WAKE_SRC = 10'h184;
  localparam logic [9:0] OFS_WAKE_EN = 10'h188;
  localparam logic [9:0] OFS_CONFIG = 10'h3f8;
  localparam logic [9:0] OFS_REVISION = 10'h3fc;

  localparam int DIV_EN_BIT = 7;
  localparam int READY_BIT = 5;
  localparam logic [31:0] RST_SEL = 32'h00000000;
  localparam logic [31:0] RST_CPU_GATES = 32'h00010003;
  localparam logic [31:0] RST_FAST_GATES = 32'h0000007f;
  localparam logic [31:0] RST_PBA_GATES = 32'h03ffffff;
  localparam logic [31:0] RST_PBB_GATES = 32'h00000007;
  localparam logic [31:0] RST_DIV_GATES = 32'h0000007f;
  localparam logic [31:0] RST_PERIPH_POWER_CONTROL = 32'h000001fa;
  localparam logic [31:0] RST_CONFIG = 32'h00000043;
  // Arbitrary neutral revision code
  localparam logic [31:0] REVISION_CODE = 32'h00000100;
  localparam logic [3:0] SETTLE_CYCLES = 4'h4;

  localparam logic [2:0] SRC_SYS_RC = 3'h0;
  localparam logic [2:0] SRC_CRYSTAL = 3'h1;
  localparam logic [2:0] SRC_FLL = 3'h2;
  localparam logic [2:0] SRC_FAST_RC = 3'h3;

  typedef struct packed {
    logic en;
    logic [2:0] ratio;
  } mcsbd_div_t;

  typedef enum logic [1:0] {
    ST_READY = 2'b01,
    ST_SETTLE = 2'b10
  } mcsbd_st_t;

  typedef struct packed {
    logic [2:0] main_sel;
    mcsbd_div_t cpu;
    mcsbd_div_t pba;
    mcsbd_div_t pbb;
    logic [31:0] cpu_gates;
    logic [31:0] fast_gates;
    logic [31:0] pba_gates;
    logic [31:0] pbb_gates;
    logic [6:0] div_gates;
    logic [31:0] fail_ctrl;
    logic [31:0] periph_power_control;
    logic [31:0] wake_en;
    mcsbd_st_t st;
    logic [3:0] settle;
    logic [7:0] cnt_cpu;
    logic [7:0] cnt_pba;
    logic [7:0] cnt_pbb;
    logic clk_cpu;
    logic clk_pba;
    logic clk_pbb;
    logic rvalid;
    logic [31:0] rdata;
  } mcsbd_state_t;
endpackage

// ### test/mcsbd_monitor.sv
// Checker on the clock select block ports
`timescale 1ns/100ps
module mcsbd_monitor
  import mcsbd_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [9:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic system_rc_oscillator,
  input wire logic crystal_oscillator,
  input wire logic frequency_locked_loop,
  input wire logic fast_rc_oscillator,
  input wire logic main_clock,
  input wire logic cpu_clock,
  input wire logic fast_bus_clock,
  input wire logic periph_bus_a_clock,
  input wire logic periph_bus_b_clock,
  input wire logic clock_settings_ready
);
  logic [2:0] msel_ff;
  logic [3:0] cpu_ff, pba_ff, pbb_ff, src, sel_w;
  logic tk, exp_main;
  assign sel_w = {avs_writedata[7], avs_writedata[2:0]};
  assign tk = avs_write && avs_waitrequest;
  assign src = {fast_rc_oscillator, frequency_locked_loop, crystal_oscillator, system_rc_oscillator};
  assign exp_main = msel_ff[2] ? system_rc_oscillator : src[msel_ff[1:0]];
  // Shadow of the select registers, taken at the accepting edge
  always_ff @(posedge mclk) begin
    if (rst) begin
      msel_ff <= 3'h0;
      cpu_ff <= 4'h0;
      pba_ff <= 4'h0;
      pbb_ff <= 4'h0;
    end else if (tk) begin
      if (avs_address == OFS_MAIN_SRC) msel_ff <= avs_writedata[2:0];
      if (avs_address == OFS_CPU_DIV) cpu_ff <= sel_w;
      if (avs_address == OFS_PBA_DIV) pba_ff <= sel_w;
      if (avs_address == OFS_PBB_DIV) pbb_ff <= sel_w;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  sequence s_take(logic [9:0] a); tk && avs_address == a; endsequence
  sequence s_settle; !clock_settings_ready [*5] ##1 clock_settings_ready; endsequence
  a_main_src_mux: assert property (main_clock == exp_main) else $error("main source wrong");
  a_cpu_undiv: assert property (!cpu_ff[3] |-> cpu_clock == main_clock)
    else $error("cpu clock not undivided");
  a_fast_mirror: assert property (fast_bus_clock == cpu_clock) else $error("fast bus differs");
  a_pba_undiv: assert property (!pba_ff[3] |-> periph_bus_a_clock == main_clock)
    else $error("bus a clock not undivided");
  a_pbb_undiv: assert property (!pbb_ff[3] |-> periph_bus_b_clock == main_clock)
    else $error("bus b clock not undivided");
  a_cpu_settle: assert property (s_take(10'h004) |=> s_settle)
    else $error("ready flag timing after cpu write");
  a_pb_settle: assert property ((s_take(10'h00c) or s_take(10'h010)) |=> s_settle)
    else $error("ready flag timing after bus write");
  a_reset_ready: assert property ($fell(rst) |-> clock_settings_ready)
    else $error("ready low after reset");
  a_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait cycle");
endmodule
bind mcsbd_main_clock_select mcsbd_monitor i_mcsbd_monitor (.mclk, .rst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_waitrequest, .system_rc_oscillator,
  .crystal_oscillator, .frequency_locked_loop, .fast_rc_oscillator, .main_clock, .cpu_clock,
  .fast_bus_clock, .periph_bus_a_clock, .periph_bus_b_clock, .clock_settings_ready);

// ### test/tb_main_clock_select_and_bus_dividers.sv
// Self-checking testbench for the clock select block
`timescale 1ns/100ps
module tb_main_clock_select_and_bus_dividers
  import mcsbd_pkg::*;
;
  logic mclk, rst, avs_read, avs_write, avs_waitrequest, main_clock, cpu_clock;
  logic fast_bus_clock, periph_bus_a_clock, periph_bus_b_clock, clock_settings_ready;
  logic [9:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdat, cpu_clock_gates, fast_bus_clock_gates;
  logic [31:0] periph_bus_a_clock_gates, periph_bus_b_clock_gates;
  logic [6:0] divided_clock_gates;
  logic [3:0] src;
  int miscompares, checks;
  logic [9:0] sa [3] = '{10'h004, 10'h00c, 10'h010};
  logic [9:0] ofs [16] = '{10'h000, 10'h004, 10'h008, 10'h00c, 10'h010, 10'h020, 10'h024,
    10'h028, 10'h02c, 10'h040, 10'h054, 10'h0d4, 10'h160, 10'h188, 10'h3f8, 10'h014};
  logic [31:0] rv [16] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h10003, 32'h7f, 32'h3ffffff,
    32'h7, 32'h7f, 32'h0, 32'h20, 32'h1fa, 32'h0, 32'h43, 32'h0};
  mcsbd_main_clock_select i_mcsbd_main_clock_select (
    .mclk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable(4'hf),
    .avs_readdata, .avs_waitrequest, .system_rc_oscillator(src[0]), .crystal_oscillator(src[1]),
    .frequency_locked_loop(src[2]), .fast_rc_oscillator(src[3]), .main_clock, .cpu_clock,
    .fast_bus_clock, .periph_bus_a_clock, .periph_bus_b_clock, .clock_settings_ready,
    .cpu_clock_gates, .fast_bus_clock_gates, .periph_bus_a_clock_gates,
    .periph_bus_b_clock_gates, .divided_clock_gates
  );
  task automatic summarize;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) miscompares++;
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task automatic rc(input string n, input logic [9:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(n, e, rdat);
  endtask
  task automatic wait_rdy;
    int n;
    n = 0;
    while (clock_settings_ready !== 1'b1 && n < 50) begin
      @(negedge mclk);
      n++;
    end
    if (n == 50) miscompares++;
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? cpu_clock : (k == 1 ? periph_bus_a_clock : periph_bus_b_clock);
  endfunction
  task automatic tgl(input int k, output int n);
    logic v;
    v = pick(k);
    n = 1;
    @(negedge mclk);
    while (pick(k) === v && n < 99) begin
      @(negedge mclk);
      n++;
    end
  endtask
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    repeat (20000) @(posedge mclk);
    miscompares++;
    summarize();
  end
  initial begin
    int n;
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 10'h0;
    avs_writedata = 32'h0;
    src = 4'h0;
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    foreach (ofs[i]) rc("reset value", ofs[i], rv[i]);
    chk("div gates", 32'h7f, {25'h0, divided_clock_gates});
    chk("cpu gates", RST_CPU_GATES, cpu_clock_gates);
    chk("fast gates", RST_FAST_GATES, fast_bus_clock_gates);
    chk("bus b gates", RST_PBB_GATES, periph_bus_b_clock_gates);
    xfer(1'b1, 10'h028, 32'h1234abcd);
    chk("bus a gates", 32'h1234abcd, periph_bus_a_clock_gates);
    xfer(1'b1, 10'h014, 32'hffffffff);
    rc("unmapped", 10'h014, 32'h0);
    src <= 4'hf;
    for (int k = 0; k < 3; k++) begin
      for (int r = 0; r < 4; r += 2) begin
        xfer(1'b1, sa[k], 32'h80 | 32'(r));
        @(negedge mclk);
        chk("ready after write", 32'h0, {31'h0, clock_settings_ready});
        wait_rdy();
        rc("status", 10'h0d4, 32'h20);
        if (k == 0) rc("fast bus mirror", 10'h008, 32'h80 | 32'(r));
        tgl(k, n);
        tgl(k, n);
        chk("half period", 32'h1 << r, 32'(n));
      end
      xfer(1'b1, sa[k], 32'h0);
      wait_rdy();
      chk("undivided", 32'h1, {31'h0, pick(k)});
    end
    xfer(1'b1, 10'h004, 32'h81);
    wait_rdy();
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, 10'h000, 32'(s));
      rc("main select", 10'h000, 32'(s));
      for (int b = 0; b < 2; b++) begin
        @(posedge mclk);
        src <= b ? 4'h1 << s : ~(4'h1 << s);
        @(negedge mclk);
        chk("main clock", 32'(b), {31'h0, main_clock});
      end
    end
    xfer(1'b1, 10'h008, 32'h0);
    rc("read-only mirror", 10'h008, 32'h81);
    xfer(1'b1, 10'h000, 32'h0);
    xfer(1'b1, 10'h004, 32'h0);
    wait_rdy();
    summarize();
  end
endmodule
